// File: rtl/tcmt_regs.svh
`ifndef TCMT_REGS_SVH
`define TCMT_REGS_SVH
// Behaviour
// - match request only while enable bit set
// - count value readable and writable up-counter
// - run bit set: count on divided clock
// - match clears count, raises request, continues
// - compare constant readable, writable, compared
// - count clock chosen from four dividers
// - separate match request output per channel
// - match signalled when count leaves matched value
// - reset into stop state; access after release
// - write colliding with match: clear wins
// - write colliding with increment: write wins
// - each counter is sixteen bits wide
// - run register: b0 channel 0, b1 channel 1
// - select 00/01/10/11 is /8 /32 /128 /512
// - match interrupt enable at control bit b6

// register indices; byte address is four times the index
`define TCMT_IDX_RUN 32'h00088000
`define TCMT_IDX_CTRL0 32'h00088002
`define TCMT_IDX_COUNT0 32'h00088004
`define TCMT_IDX_COMPARE0 32'h00088006
`define TCMT_IDX_CTRL1 32'h00088008
`define TCMT_IDX_COUNT1 32'h0008800a
`define TCMT_IDX_COMPARE1 32'h0008800c
`define TCMT_IDX_STOP 32'h00088010
`define TCMT_IDX_STATUS 32'h00088012
`define TCMT_IDX_MASK 32'h00088014

// field positions
`define TCMT_CKS_MSB 1
`define TCMT_CKS_LSB 0
`define TCMT_IRQ_EN_BIT 6
`define TCMT_STOP_BIT 0

// reset values
`define TCMT_STOP_RESET 1'b1
`define TCMT_COUNT_CLEAR 16'h0000
`define TCMT_COMPARE_RESET 16'hffff

// clock select codes and prescaler masks
`define TCMT_CKS_DIV8 2'h0
`define TCMT_CKS_DIV32 2'h1
`define TCMT_CKS_DIV128 2'h2
`define TCMT_CKS_DIV512 2'h3
`define TCMT_DIV8_MASK 9'h007
`define TCMT_DIV32_MASK 9'h01f
`define TCMT_DIV128_MASK 9'h07f
`define TCMT_DIV512_MASK 9'h1ff

`endif

// File: rtl/tcmt_pkg.sv
package tcmt_pkg;

	// bus data phase states, one-hot
	typedef enum logic [3:0] {
		TCMT_PH_IDLE = 4'b0001,
		TCMT_PH_WRITE = 4'b0010,
		TCMT_PH_RD_WAIT = 4'b0100,
		TCMT_PH_RD_DONE = 4'b1000
	} tcmt_phase_e;

	// address phase captured for the following data phase
	typedef struct packed {
		logic [31:0] addr;
		logic word;
	} tcmt_addr_s;

endpackage

// File: rtl/tcmt_timer.sv
`timescale 1ns/100ps
`include "tcmt_regs.svh"

module tcmt_timer #(
	parameter int CNT_W = 16,
	parameter int PRESC_W = 9
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [1:0] match_irq,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////
	// state

	tcmt_pkg::tcmt_phase_e phase_reg;
	tcmt_pkg::tcmt_phase_e phase_next;
	tcmt_pkg::tcmt_addr_s addr_reg;
	logic stop_reg;
	logic [1:0] run_reg;
	logic [1:0] cks_reg [2];
	logic [1:0] irq_en_reg;
	logic [CNT_W-1:0] count_reg [2];
	logic [CNT_W-1:0] compare_reg [2];
	logic [PRESC_W-1:0] presc_reg;
	logic [1:0] status_reg;
	logic [1:0] mask_reg;
	logic [1:0] match_irq_reg;
	logic [31:0] rdata_reg;

	logic accept;
	logic wr_ok;
	logic cmt_open;
	logic wr_run;
	logic wr_stop;
	logic wr_status;
	logic wr_mask;
	logic [1:0] wr_ctrl;
	logic [1:0] wr_count;
	logic [1:0] wr_compare;
	logic [1:0] tick;
	logic [1:0] equal;
	logic [1:0] match_evt;
	logic [1:0] inc_evt;

	////////////////////////////////////////////////////////////////////////////
	// functions

	// true when the address equals the byte address of a register index
	function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
		return a == {idx[29:0], 2'b00};
	endfunction

	// prescaler bits that must all be one for a count clock edge
	function automatic logic [PRESC_W-1:0] div_mask(input logic [1:0] sel);
		logic [PRESC_W-1:0] m;
		m = PRESC_W'(`TCMT_DIV512_MASK);
		case (sel)
			`TCMT_CKS_DIV8: m = PRESC_W'(`TCMT_DIV8_MASK);
			`TCMT_CKS_DIV32: m = PRESC_W'(`TCMT_DIV32_MASK);
			`TCMT_CKS_DIV128: m = PRESC_W'(`TCMT_DIV128_MASK);
			`TCMT_CKS_DIV512: m = PRESC_W'(`TCMT_DIV512_MASK);
			default: m = PRESC_W'(`TCMT_DIV512_MASK);
		endcase
		return m;
	endfunction

	// read view of every register; timer registers read zero while stopped
	function automatic logic [31:0] rd_word(input logic [31:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (hit(a, `TCMT_IDX_STOP)) begin
			r[`TCMT_STOP_BIT] = stop_reg;
		end else if (!stop_reg) begin
			if (hit(a, `TCMT_IDX_RUN)) begin
				r[1:0] = run_reg;
			end else if (hit(a, `TCMT_IDX_CTRL0)) begin
				r[`TCMT_CKS_MSB:`TCMT_CKS_LSB] = cks_reg[0];
				r[`TCMT_IRQ_EN_BIT] = irq_en_reg[0];
			end else if (hit(a, `TCMT_IDX_CTRL1)) begin
				r[`TCMT_CKS_MSB:`TCMT_CKS_LSB] = cks_reg[1];
				r[`TCMT_IRQ_EN_BIT] = irq_en_reg[1];
			end else if (hit(a, `TCMT_IDX_COUNT0)) begin
				r[CNT_W-1:0] = count_reg[0];
			end else if (hit(a, `TCMT_IDX_COUNT1)) begin
				r[CNT_W-1:0] = count_reg[1];
			end else if (hit(a, `TCMT_IDX_COMPARE0)) begin
				r[CNT_W-1:0] = compare_reg[0];
			end else if (hit(a, `TCMT_IDX_COMPARE1)) begin
				r[CNT_W-1:0] = compare_reg[1];
			end else if (hit(a, `TCMT_IDX_STATUS)) begin
				r[1:0] = status_reg;
			end else if (hit(a, `TCMT_IDX_MASK)) begin
				r[1:0] = mask_reg;
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// bus slave

	// a read costs one wait state so a write just before it has landed
	assign accept = hsel && hready && htrans[1];
	assign hreadyout = (phase_reg != tcmt_pkg::TCMT_PH_RD_WAIT);
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;

	always_comb begin
		phase_next = tcmt_pkg::TCMT_PH_IDLE;
		case (phase_reg)
			tcmt_pkg::TCMT_PH_RD_WAIT: phase_next = tcmt_pkg::TCMT_PH_RD_DONE;
			default: begin
				if (accept) begin
					phase_next = hwrite ? tcmt_pkg::TCMT_PH_WRITE : tcmt_pkg::TCMT_PH_RD_WAIT;
				end
			end
		endcase
	end

	// data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_reg <= tcmt_pkg::TCMT_PH_IDLE;
			addr_reg <= '0;
		end else begin
			phase_reg <= phase_next;
			if (accept) begin
				addr_reg.addr <= haddr;
				addr_reg.word <= (hsize == 3'h2);
			end
		end
	end

	// read data is registered in the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (phase_reg == tcmt_pkg::TCMT_PH_RD_WAIT) begin
			rdata_reg <= rd_word(addr_reg.addr);
		end
	end

	// write strobes; only whole-word writes are honoured
	assign wr_ok = (phase_reg == tcmt_pkg::TCMT_PH_WRITE) && addr_reg.word;
	assign cmt_open = !stop_reg;
	assign wr_stop = wr_ok && hit(addr_reg.addr, `TCMT_IDX_STOP);
	assign wr_run = wr_ok && cmt_open && hit(addr_reg.addr, `TCMT_IDX_RUN);
	assign wr_status = wr_ok && cmt_open && hit(addr_reg.addr, `TCMT_IDX_STATUS);
	assign wr_mask = wr_ok && cmt_open && hit(addr_reg.addr, `TCMT_IDX_MASK);

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			wr_ctrl[i] = wr_ok && cmt_open &&
				hit(addr_reg.addr, (i == 0) ? `TCMT_IDX_CTRL0 : `TCMT_IDX_CTRL1);
			wr_count[i] = wr_ok && cmt_open &&
				hit(addr_reg.addr, (i == 0) ? `TCMT_IDX_COUNT0 : `TCMT_IDX_COUNT1);
			wr_compare[i] = wr_ok && cmt_open &&
				hit(addr_reg.addr, (i == 0) ? `TCMT_IDX_COMPARE0 : `TCMT_IDX_COMPARE1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control registers

	// module stop, set at reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_reg <= `TCMT_STOP_RESET;
		end else if (wr_stop) begin
			stop_reg <= hwdata[`TCMT_STOP_BIT];
		end
	end

	// shared run bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_reg <= 2'h0;
		end else if (wr_run) begin
			run_reg <= hwdata[1:0];
		end
	end

	// per-channel clock select and interrupt enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cks_reg[0] <= `TCMT_CKS_DIV8;
			cks_reg[1] <= `TCMT_CKS_DIV8;
			irq_en_reg <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_ctrl[i]) begin
					cks_reg[i] <= hwdata[`TCMT_CKS_MSB:`TCMT_CKS_LSB];
					irq_en_reg[i] <= hwdata[`TCMT_IRQ_EN_BIT];
				end
			end
		end
	end

	// compare constants
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			compare_reg[0] <= CNT_W'(`TCMT_COMPARE_RESET);
			compare_reg[1] <= CNT_W'(`TCMT_COMPARE_RESET);
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_compare[i]) begin
					compare_reg[i] <= hwdata[CNT_W-1:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// prescaler and counters

	// one shared prescaler keeps both channels phase-aligned; frozen when stopped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_reg <= '0;
		end else if (cmt_open) begin
			presc_reg <= presc_reg + PRESC_W'(1);
		end
	end

	// count clock edges and events per channel
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			tick[i] = cmt_open && ((presc_reg & div_mask(cks_reg[i])) == div_mask(cks_reg[i]));
			equal[i] = (count_reg[i] == compare_reg[i]);
			match_evt[i] = tick[i] && run_reg[i] && equal[i];
			inc_evt[i] = tick[i] && run_reg[i] && !equal[i];
		end
	end

	// match clears first, then a write, then the increment
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count_reg[0] <= CNT_W'(`TCMT_COUNT_CLEAR);
			count_reg[1] <= CNT_W'(`TCMT_COUNT_CLEAR);
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (match_evt[i]) begin
					count_reg[i] <= CNT_W'(`TCMT_COUNT_CLEAR);
				end else if (wr_count[i]) begin
					count_reg[i] <= hwdata[CNT_W-1:0];
				end else if (inc_evt[i]) begin
					count_reg[i] <= count_reg[i] + CNT_W'(1);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts

	// per-channel request pulse, gated by the channel's enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			match_irq_reg <= 2'h0;
		end else begin
			match_irq_reg <= match_evt & irq_en_reg;
		end
	end

	// sticky status, write one to clear; a new match beats the clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_reg <= 2'h0;
		end else begin
			status_reg <= (status_reg & ~(wr_status ? hwdata[1:0] : 2'h0)) | match_evt;
		end
	end

	// interrupt mask
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_reg <= 2'h0;
		end else if (wr_mask) begin
			mask_reg <= hwdata[1:0];
		end
	end

	assign match_irq = match_irq_reg;
	assign irq = |(status_reg & mask_reg);

	////////////////////////////////////////////////////////////////////////////
	// assertions

	irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		match_irq[0] |-> $past(irq_en_reg[0]) && $past(match_evt[0]))
		else $error("channel 0 request without enable or match");

	irq_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$past(match_evt[1]) && $past(irq_en_reg[1]) |-> match_irq[1] && count_reg[1] == '0)
		else $error("channel 1 match did not raise its request");

	count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
		inc_evt[0] && !wr_count[0] |=> count_reg[0] == $past(count_reg[0]) + CNT_W'(1))
		else $error("channel 0 count did not advance by one");

	match_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		match_evt[1] |=> count_reg[1] == '0 && status_reg[1])
		else $error("channel 1 match did not clear the count");

	match_late_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(equal[0]) && run_reg[0] && !tick[0] |=> !match_irq[0])
		else $error("match signalled on first equality");

	write_lose_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_count[0] && match_evt[0] |=> count_reg[0] == '0)
		else $error("write beat a match clear");

	write_win_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_count[1] && !match_evt[1] |=> count_reg[1] == $past(hwdata[CNT_W-1:0]))
		else $error("write lost to an increment");

	stop_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
		stop_reg && phase_reg == tcmt_pkg::TCMT_PH_WRITE |=> $stable(run_reg) && $stable(mask_reg))
		else $error("register changed in module stop");

	run_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!run_reg[0] && !wr_count[0] |=> $stable(count_reg[0]) && !match_irq[0])
		else $error("stopped channel 0 changed its count");

	div_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick[1] && cks_reg[1] == `TCMT_CKS_DIV32 |-> presc_reg[4:0] == 5'h1f ##1 (!tick[1]) [*8])
		else $error("divide by 32 edge out of place");

	read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		accept && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state missing");

endmodule

// File: testbench/two_channel_compare_match_timer_tb.sv
`timescale 1ns/100ps
`include "tcmt_regs.svh"

module two_channel_compare_match_timer_tb;

	localparam logic [31:0] A_RUN = `TCMT_IDX_RUN << 2;
	localparam logic [31:0] A_CTL0 = `TCMT_IDX_CTRL0 << 2;
	localparam logic [31:0] A_CNT0 = `TCMT_IDX_COUNT0 << 2;
	localparam logic [31:0] A_CMP0 = `TCMT_IDX_COMPARE0 << 2;
	localparam logic [31:0] A_CTL1 = `TCMT_IDX_CTRL1 << 2;
	localparam logic [31:0] A_CNT1 = `TCMT_IDX_COUNT1 << 2;
	localparam logic [31:0] A_CMP1 = `TCMT_IDX_COMPARE1 << 2;
	localparam logic [31:0] A_STOP = `TCMT_IDX_STOP << 2;
	localparam logic [31:0] A_STAT = `TCMT_IDX_STATUS << 2;
	localparam logic [31:0] A_MASK = `TCMT_IDX_MASK << 2;
	localparam int LIMIT = 20000;

	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, match_irq;
	logic [2:0] hsize;
	logic hreadyout, hresp, irq;
	wire logic hready;
	int n_mismatch = 0;
	int checks = 0;
	int cycles = 0;

	// single slave: its ready is the bus ready
	assign hready = hreadyout;

	tcmt_timer dut (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.match_irq(match_irq),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard; the guard bound covers the slowest divider runs nearly ten times over
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			n_mismatch++;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// address phase held until ready seen high, then data phase until ready again
	task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
		hsel <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(a, 1'b1, d, q);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] q);
		xfer(a, 1'b0, 32'h0, q);
	endtask

	// counts falling edges until the channel request is seen; pulses last one cycle
	task automatic wait_irq(input int ch, output int n);
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (match_irq[ch] !== 1'b1 && n < 3000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] d, v;
		int n;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rd(A_STOP, d); chk("stop", 32'h1, d);
		wr(A_CMP0, 32'h5); rd(A_CMP0, d); chk("cmp0 stopped", 32'h0, d);
		wr(A_STOP, 32'h0);
		rd(A_CMP0, d); chk("cmp0 reset", 32'hffff, d);
		wr(A_CMP0, 32'hffffffff); rd(A_CMP0, d); chk("cmp0 width", 32'hffff, d);
		wr(A_CNT0, 32'h1234); rd(A_CNT0, d); chk("cnt0", 32'h1234, d);
		wr(A_CMP1, 32'habcd); rd(A_CMP1, d); chk("cmp1", 32'habcd, d);
		// a byte-sized write must be dropped
		hsize <= 3'h0;
		wr(A_CMP1, 32'h7); hsize <= 3'h2;
		rd(A_CMP1, d); chk("cmp1 byte write", 32'habcd, d);
		rd(32'h00220100, d); chk("unmapped", 32'h0, d);
		// channel 0 at /8 with compare 3: a request every 32 cycles
		wr(A_CNT0, 32'h0);
		wr(A_CMP0, 32'h3);
		wr(A_CTL0, 32'h40);
		wr(A_MASK, 32'h1);
		wr(A_RUN, 32'h1);
		wait_irq(0, n);
		wait_irq(0, n); chk("period0", 32'd32, n);
		chk("irq set", 32'h1, {31'h0, irq});
		// the write lands on the count clock edge eight cycles after the match
		repeat (5) @(posedge hclk);
		wr(A_CNT0, 32'h10); rd(A_CNT0, d); chk("write vs inc", 32'h10, d);
		// compare zero matches on every count edge, so a colliding write is lost
		wr(A_CMP0, 32'h0);
		wr(A_CNT0, 32'h0);
		wait_irq(0, n);
		repeat (5) @(posedge hclk);
		wr(A_CNT0, 32'h100); rd(A_CNT0, d); chk("write vs match", 32'h0, d);
		wr(A_RUN, 32'h0);
		rd(A_STAT, d); chk("status ch0", 32'h1, d);
		wr(A_MASK, 32'h0); #1 chk("irq masked", 32'h0, {31'h0, irq});
		wr(A_MASK, 32'h1);
		wr(A_STAT, 32'h1); #1 chk("irq cleared", 32'h0, {31'h0, irq});
		rd(A_STAT, d); chk("status clear", 32'h0, d);
		wr(A_CNT0, 32'h55); rd(A_CNT0, v); chk("cnt0 write", 32'h55, v);
		// each divider on channel 1, compare 1: period is twice the division
		wr(A_CMP1, 32'h1);
		for (int k = 0; k < 4; k++) begin
			wr(A_CTL1, 32'h40 | k);
			wr(A_RUN, 32'h2);
			wait_irq(1, n);
			wait_irq(1, n); chk("period1", 32'd16 << (2 * k), n);
			wr(A_RUN, 32'h0);
		end
		rd(A_CNT0, d); chk("cnt0 held", v, d);
		wr(A_CNT1, 32'h1); rd(A_CNT1, d); chk("cnt1", 32'h1, d);
		// enable clear: status still records matches, no request leaves
		wr(A_CTL1, 32'h0);
		wr(A_STAT, 32'h3);
		wr(A_RUN, 32'h2);
		n = 0;
		repeat (100) begin
			@(negedge hclk);
			if (match_irq[1] !== 1'b0)
				n++;
		end
		chk("no request", 32'h0, n);
		wr(A_RUN, 32'h0);
		rd(A_STAT, d); chk("status ch1", 32'h2, d);
		end_of_test();
	end

endmodule
